// ---- frontend_delay.sv ----
// front-end sampling delay with deferred power configuration
module frontend_delay
  import monitor_cfg_pkg::*;
#(
  parameter int DELAY_CYCLES = FE_DELAY_CYCLES
)(
  input  wire logic     core_clk,
  input  wire logic     rst,
  sample_ctrl_if.delay_side sc
);

  localparam int CW = $clog2(DELAY_CYCLES + 1);

  initial
  begin
    if (DELAY_CYCLES < 1)
      $error("frontend_delay: DELAY_CYCLES must be at least 1");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } dly_state_t;

  typedef struct packed {
    dly_state_t    st;
    logic [CW-1:0] cnt;
    logic          active;
    logic          pending;
    logic          pend_val;
    logic          go;
  } dly_t;

  dly_t s_q;
  dly_t s_d;

  always_comb
  begin
    s_d    = s_q;
    s_d.go = 1'b0;
    // a new setting waits for the end of the next sample [R14]
    if (sc.sample_done && s_q.pending)
    begin
      s_d.active  = s_q.pend_val;
      s_d.pending = 1'b0;
    end
    if (sc.pwr_wr)
    begin
      s_d.pending  = 1'b1;
      s_d.pend_val = sc.pwr_val[FE_DELAY_BIT];
    end
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (sc.sample_req)
        begin
          // the delay applies even when the front end is already up [R13]
          if (s_q.active)
          begin
            s_d.st  = ST_WAIT;
            s_d.cnt = CW'(DELAY_CYCLES - 1);
          end
          else
            s_d.go = 1'b1;
        end
      end
      ST_WAIT:
      begin
        // requests during the wait are absorbed, not queued
        if (s_q.cnt == '0)
        begin
          s_d.go = 1'b1;
          s_d.st = ST_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - CW'(1);
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q.st       <= ST_IDLE;
      s_q.cnt      <= '0;
      s_q.active   <= PWR_OPT_RST[FE_DELAY_BIT];
      s_q.pending  <= 1'b0;
      s_q.pend_val <= 1'b0;
      s_q.go       <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign sc.sample_go = s_q.go;
  assign sc.delay_on  = s_q.active;
  assign sc.busy      = (s_q.st == ST_WAIT);

endmodule

// ---- frontend_model.sv ----
// front-end sampler model
module frontend_model #(
  parameter int LAT = 3
)(
  input  logic core_clk,
  input  logic rst,
  input  logic sample_go,
  output logic sample_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;
  // fixed conversion time; only the done pulse matters
  always @(posedge core_clk)
  begin
    sample_done <= 1'b0;
    if (rst)
      cnt_q <= 0;
    else if (sample_go)
      cnt_q <= LAT;
    else if (cnt_q > 0)
    begin
      cnt_q <= cnt_q - 1;
      sample_done <= (cnt_q == 1);
    end
  end
endmodule

// ---- monitor_cfg_asserts.sv ----
// port checks for the monitor configuration register bank
module monitor_cfg_asserts
  import monitor_cfg_pkg::*;
#(
  parameter int DELAY_CYCLES = FE_DELAY_CYCLES
)(
  input logic        core_clk,
  input logic        rst,
  input logic        comm_reset,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [7:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic [7:0]  reg_rdata,
  input logic        reg_rvalid,
  input logic [15:0] channel_active,
  input logic [4:0]  idle_channel,
  input logic [15:0] ov_comp_on,
  input logic [15:0] cell_ov_raw,
  input logic [15:0] cell_ov_fault,
  input logic        system_reset_flag,
  input logic        regulator_drive,
  input logic        sample_req,
  input logic        sample_go,
  input logic        sample_wait,
  input logic        frontend_power_delay,
  input logic [1:0]  baud_sel,
  input logic        tx_pin,
  input logic        fault_n_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // **********
  // helpers
  // **********
  function automatic logic [15:0] used_mask(logic [4:0] c);
    return (c >= 5'h10) ? 16'hffff : 16'((17'h1 << c) - 17'h1);
  endfunction
  function automatic logic [4:0] idle_of(logic [4:0] c);
    return (c == 5'h0) ? 5'h1 : ((c > 5'h10) ? 5'h10 : c);
  endfunction
  // delay cycles of the running sample
  int unsigned wait_cnt_q;
  always_ff @(posedge core_clk)
    if (rst || sample_go)
      wait_cnt_q <= 0;
    else if (sample_wait)
      wait_cnt_q <= wait_cnt_q + 1;
  sequence chan_wr_s;
    reg_wr && reg_addr == ADDR_CHAN_COUNT;
  endsequence
  sequence quick_req_s;
    sample_req && !sample_wait && !frontend_power_delay;
  endsequence

  // **********
  // properties
  // **********
  chan_mask_a: assert property (chan_wr_s |=> channel_active == used_mask($past(reg_wdata[4:0])))
    else $error("channel mask wrong");
  idle_chan_a: assert property (chan_wr_s |=> idle_channel == idle_of($past(reg_wdata[4:0])))
    else $error("idle channel wrong");
  comp_unused_a: assert property ((ov_comp_on & ~channel_active) == 16'h0)
    else $error("comparator on unused");
  fault_mask_a: assert property (!$past(rst) |-> cell_ov_fault == $past(cell_ov_raw & ov_comp_on))
    else $error("ov fault not masked");
  reg_drive_a: assert property (reg_wr && reg_addr == ADDR_DEV_OPT && !system_reset_flag ##1 !system_reset_flag |-> regulator_drive == !$past(reg_wdata[REG_DIS_BIT]))
    else $error("regulator drive wrong");
  reg_hold_a: assert property (system_reset_flag |-> regulator_drive)
    else $error("regulator off in reset");
  fe_delay_a: assert property (sample_go |-> wait_cnt_q == (frontend_power_delay ? DELAY_CYCLES : 0))
    else $error("delay length wrong");
  go_now_a: assert property (quick_req_s |=> sample_go)
    else $error("quick sample late");
  baud_write_a: assert property (reg_wr && reg_addr == ADDR_LINK_HI && !comm_reset |=> baud_sel == $past(reg_wdata[5:4]))
    else $error("baud write lost");
  baud_reset_a: assert property (comm_reset |=> baud_sel == BAUD_250K)
    else $error("baud not reset");
  tx_idle_a: assert property (reg_wr && reg_addr == ADDR_LINK_LO && !reg_wdata[SE_EN_BIT] |=> ##[0:1] (tx_pin && !fault_n_pin))
    else $error("se pins not parked");
  read_unmapped_a: assert property (reg_rd && (reg_addr < ADDR_CHAN_COUNT || reg_addr > ADDR_LINK_LO) |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read wrong");
endmodule

bind monitor_config_registers monitor_cfg_asserts #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (
  .core_clk, .rst, .comm_reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .channel_active, .idle_channel, .ov_comp_on, .cell_ov_raw, .cell_ov_fault,
  .system_reset_flag, .regulator_drive, .sample_req, .sample_go, .sample_wait,
  .frontend_power_delay, .baud_sel, .tx_pin, .fault_n_pin
);

// ---- monitor_cfg_pkg.sv ----
// constants, field layout and reset values of the monitor configuration registers
package monitor_cfg_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_CHAN_COUNT = 8'h0d;
  localparam logic [7:0] ADDR_DEV_OPT    = 8'h0e;
  localparam logic [7:0] ADDR_PWR_OPT    = 8'h0f;
  localparam logic [7:0] ADDR_LINK_HI    = 8'h10;
  localparam logic [7:0] ADDR_LINK_LO    = 8'h11;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CHAN_COUNT_MSB = 4;
  localparam int REG_DIS_BIT    = 5;
  localparam int ADDR_SEL_BIT   = 4;
  localparam int COMP_CFG_LSB   = 2;
  localparam int HYST_BIT       = 1;
  localparam int UNLATCH_BIT    = 0;
  localparam int FE_DELAY_BIT   = 7;
  localparam int BAUD_LSB       = 12;
  localparam int SE_EN_BIT      = 7;
  localparam int UPPER_RX_BIT   = 6;
  localparam int LOWER_TX_BIT   = 5;
  localparam int FAULT_RX_BIT   = 4;
  localparam int HEARTBEAT_BIT  = 3;

  // writable bits; everything else is reserved and reads as zero
  localparam logic [7:0]  CHAN_WMASK = 8'h1f;
  localparam logic [7:0]  DEV_WMASK  = 8'h3f;
  localparam logic [7:0]  PWR_WMASK  = 8'h80;
  localparam logic [15:0] LINK_WMASK = 16'h30f8;

  // ************************************************************
  // cell count and values after reset
  // ************************************************************
  localparam int          NUM_CELLS      = 16;
  localparam logic [4:0]  CHAN_COUNT_RST = 5'h10;
  localparam logic [7:0]  DEV_OPT_RST    = 8'h00;
  localparam logic [7:0]  PWR_OPT_RST    = 8'h80;
  localparam logic [15:0] LINK_OPT_RST   = 16'h10f8;
  localparam logic [4:0]  NODE_ADDR_RST  = 5'h00;

  // ************************************************************
  // modes
  // ************************************************************
  typedef enum logic [1:0] {
    BAUD_125K = 2'h0,
    BAUD_250K = 2'h1,
    BAUD_500K = 2'h2,
    BAUD_1M   = 2'h3
  } baud_t;

  typedef enum logic [1:0] {
    COMP_BOTH    = 2'h0,
    COMP_OV_ONLY = 2'h1,
    COMP_OFF     = 2'h2,
    COMP_RSVD    = 2'h3
  } comp_mode_t;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ          = 10_000_000;
  localparam int FE_DELAY_US     = 100;
  localparam int FE_DELAY_CYCLES = (FE_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int BAUD_125K_HZ    = 125_000;
  localparam int BAUD_250K_HZ    = 250_000;
  localparam int BAUD_500K_HZ    = 500_000;
  localparam int BAUD_1M_HZ      = 1_000_000;
  localparam logic [7:0] DIV_125K = 8'(CLK_HZ / BAUD_125K_HZ);
  localparam logic [7:0] DIV_250K = 8'(CLK_HZ / BAUD_250K_HZ);
  localparam logic [7:0] DIV_500K = 8'(CLK_HZ / BAUD_500K_HZ);
  localparam logic [7:0] DIV_1M   = 8'(CLK_HZ / BAUD_1M_HZ);

endpackage

// ---- monitor_config_registers.sv ----
// configuration register bank of the stackable battery monitor
//
// Operation
// R1: five-bit count sets active sense inputs; inactive ones drop from channel 16 down.
// R2: idle multiplexer channel equals the count; zero parks on sense input 1.
// R3: channels beyond the count lose OV/UV fault reporting and their comparators.
// R4: software never programs a count above 16.
// R5: regulator-disable bit 5 at 0 drives the regulator, at 1 stops it.
// R6: regulator stays enabled while the system reset flag is set.
// R7: address-source bit 4: 0 samples GPIO inputs, 1 uses auto addressing.
// R8: writing the address-source bit leaves the current node address unchanged.
// R9: comparator field: 0 both, 1 OV only, 2 none, 3 reserved.
// R10: bit 1 set enables comparator hysteresis, cleared disables it.
// R11: bit 0 chooses latched faults (0) or self-clearing faults (1).
// R12: software changes the latching bit only while no fault is pending.
// R13: power bit 7 set delays every sampling request by 100 us; requests that arrive during the delay are dropped.
// R14: a power configuration write takes effect after the next sample completes.
// R15: baud field: 0 125K, 1 250K, 2 500K, 3 1M.
// R16: communication reset returns the baud field to 250 Kbaud.
// R17: single-ended enable 0 disables transmitter: TX high, fault output low.
// R18: bit 6 enables the high-side differential receiver.
// R19: bit 5 enables the low-side differential transmitter.
// R20: bit 4 enables the high-side differential fault receiver.
// R21: bit 3 enables the heartbeat on the differential fault output.
// R22: software writes zero to every reserved bit.
// R23: auto-address command with auto source selected enters auto-addressing mode.
// R24: writes act on the next cycle; reserved bits read back as zero.
module monitor_config_registers
  import monitor_cfg_pkg::*;
#(
  parameter int DELAY_CYCLES = FE_DELAY_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        comm_reset,
  // register access from the command decoder
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // addressing
  input  wire logic [4:0]  gpio_addr_pin,
  input  wire logic        auto_address_cmd,
  input  wire logic        addr_assign,
  input  wire logic [4:0]  addr_assign_val,
  input  wire logic        frame_received,
  output logic      [4:0]  node_address,
  output logic             auto_addr_mode,
  // cell channels and comparators
  output logic      [15:0] channel_active,
  output logic      [4:0]  idle_channel,
  output logic      [15:0] ov_comp_on,
  output logic      [15:0] uv_comp_on,
  input  wire logic [15:0] cell_ov_raw,
  input  wire logic [15:0] cell_uv_raw,
  output logic      [15:0] cell_ov_fault,
  output logic      [15:0] cell_uv_fault,
  output logic             hysteresis_on,
  output logic             faults_unlatched,
  // supply
  input  wire logic        system_reset_flag,
  output logic             regulator_drive,
  // front-end sampling
  input  wire logic        sample_req,
  input  wire logic        sample_done,
  output logic             sample_go,
  output logic             sample_wait,
  output logic             frontend_power_delay,
  // link
  output logic      [1:0]  baud_sel,
  output logic      [7:0]  bit_period_cycles,
  input  wire logic        tx_raw,
  input  wire logic        fault_n_raw,
  output logic             tx_pin,
  output logic             fault_n_pin,
  output logic             upper_receiver_on,
  output logic             lower_transmitter_on,
  output logic             fault_receiver_on,
  output logic             fault_heartbeat_on
);

  initial
  begin
    if (DELAY_CYCLES < 1)
      $error("monitor_config_registers: DELAY_CYCLES must be at least 1");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [4:0]  chan_count;
    logic [7:0]  dev_opt;
    logic [7:0]  pwr_opt;
    logic [15:0] link_opt;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [4:0]  gpio_s1;
    logic [4:0]  gpio_s2;
    logic [4:0]  gpio_s3;
    logic [4:0]  gpio_stable;
    logic [4:0]  node_addr;
    logic        auto_mode;
    logic [15:0] ov_fault;
    logic [15:0] uv_fault;
    logic        tx;
    logic        fault_n;
    logic [7:0]  bit_period;
  } cfg_state_t;

  cfg_state_t s_q;
  cfg_state_t s_d;

  sample_ctrl_if sc ();

  // ************************************************************
  // per-channel decode
  // ************************************************************
  logic [4:0]  count_eff;
  comp_mode_t  comp_mode;
  logic        ov_allowed;
  logic        uv_allowed;

  // reserved counts above 16 behave as 16 so no channel index overflows [R4]
  assign count_eff  = (s_q.chan_count > 5'(NUM_CELLS)) ? 5'(NUM_CELLS) : s_q.chan_count;
  assign comp_mode  = comp_mode_t'(s_q.dev_opt[COMP_CFG_LSB +: 2]);
  // the reserved comparator code is treated as all off [R9]
  assign ov_allowed = (comp_mode == COMP_BOTH) || (comp_mode == COMP_OV_ONLY);
  assign uv_allowed = (comp_mode == COMP_BOTH);

  for (genvar i = 0; i < NUM_CELLS; i++)
  begin : g_chan
    // inputs vanish from the top channel downward [R1]
    assign channel_active[i] = (count_eff > 5'(i));
    // comparators of unused channels are powered down [R3] [R9]
    assign ov_comp_on[i] = channel_active[i] && ov_allowed;
    assign uv_comp_on[i] = channel_active[i] && uv_allowed;
  end

  // ************************************************************
  // register writes, reads and derived state
  // ************************************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;

    // three-stage pin synchroniser; a change counts once stages two and three agree
    s_d.gpio_s1 = gpio_addr_pin;
    s_d.gpio_s2 = s_q.gpio_s1;
    s_d.gpio_s3 = s_q.gpio_s2;
    if (s_q.gpio_s2 == s_q.gpio_s3)
      s_d.gpio_stable = s_q.gpio_s3;

    if (reg_wr)
    begin
      // reserved bits are dropped on write so they always read as zero [R22] [R24]
      unique case (reg_addr)
        ADDR_CHAN_COUNT: s_d.chan_count = reg_wdata[CHAN_COUNT_MSB:0];
        // a new address source never disturbs the address in use [R8]
        ADDR_DEV_OPT:    s_d.dev_opt = reg_wdata & DEV_WMASK;
        ADDR_PWR_OPT:    s_d.pwr_opt = reg_wdata & PWR_WMASK;
        ADDR_LINK_HI:    s_d.link_opt[15:8] = reg_wdata & LINK_WMASK[15:8];
        ADDR_LINK_LO:    s_d.link_opt[7:0] = reg_wdata & LINK_WMASK[7:0];
        default:         s_d.rvalid = 1'b0;
      endcase
    end

    // communication reset overrides a same-cycle write of the baud field [R16]
    if (comm_reset)
      s_d.link_opt[BAUD_LSB +: 2] = BAUD_250K;

    if (reg_rd)
    begin
      s_d.rvalid = 1'b1;
      unique case (reg_addr)
        ADDR_CHAN_COUNT: s_d.rdata = {3'h0, s_q.chan_count};
        ADDR_DEV_OPT:    s_d.rdata = s_q.dev_opt;
        ADDR_PWR_OPT:    s_d.rdata = s_q.pwr_opt;
        ADDR_LINK_HI:    s_d.rdata = s_q.link_opt[15:8];
        ADDR_LINK_LO:    s_d.rdata = s_q.link_opt[7:0];
        default:         s_d.rdata = 8'h00;
      endcase
    end

    // address source: gpio sample or auto-addressing mode [R7] [R23]
    if (addr_assign && s_q.auto_mode)
      s_d.node_addr = addr_assign_val;
    if (frame_received)
      s_d.auto_mode = 1'b0;
    if (auto_address_cmd)
    begin
      if (s_q.dev_opt[ADDR_SEL_BIT])
        s_d.auto_mode = 1'b1;
      else
        s_d.node_addr = s_q.gpio_stable;
    end

    // faults of unused channels or disabled comparators are never reported [R3]
    s_d.ov_fault = cell_ov_raw & ov_comp_on;
    s_d.uv_fault = cell_uv_raw & uv_comp_on;

    // disabled single-ended port still drives: TX idles high, fault output low [R17]
    s_d.tx      = s_q.link_opt[SE_EN_BIT] ? tx_raw : 1'b1;
    s_d.fault_n = s_q.link_opt[SE_EN_BIT] ? fault_n_raw : 1'b0;

    // bit period of the serial link in core clocks [R15]
    unique case (baud_t'(s_q.link_opt[BAUD_LSB +: 2]))
      BAUD_125K: s_d.bit_period = DIV_125K;
      BAUD_250K: s_d.bit_period = DIV_250K;
      BAUD_500K: s_d.bit_period = DIV_500K;
      BAUD_1M:   s_d.bit_period = DIV_1M;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q.chan_count  <= CHAN_COUNT_RST;
      s_q.dev_opt     <= DEV_OPT_RST;
      s_q.pwr_opt     <= PWR_OPT_RST;
      s_q.link_opt    <= LINK_OPT_RST;
      s_q.rdata       <= 8'h00;
      s_q.rvalid      <= 1'b0;
      s_q.gpio_s1     <= 5'h00;
      s_q.gpio_s2     <= 5'h00;
      s_q.gpio_s3     <= 5'h00;
      s_q.gpio_stable <= 5'h00;
      s_q.node_addr   <= NODE_ADDR_RST;
      s_q.auto_mode   <= 1'b0;
      s_q.ov_fault    <= 16'h0000;
      s_q.uv_fault    <= 16'h0000;
      s_q.tx          <= 1'b1;
      s_q.fault_n     <= 1'b0;
      s_q.bit_period  <= DIV_250K;
    end
    else
      s_q <= s_d;
  end

  // ************************************************************
  // front-end sampling delay
  // ************************************************************
  assign sc.sample_req  = sample_req;
  assign sc.sample_done = sample_done;
  // only a write to the power register hands a new setting over [R14]
  assign sc.pwr_wr      = reg_wr && (reg_addr == ADDR_PWR_OPT);
  assign sc.pwr_val     = reg_wdata & PWR_WMASK;

  frontend_delay #(
    .DELAY_CYCLES (DELAY_CYCLES)
  ) u_delay (
    .core_clk (core_clk),
    .rst      (rst),
    .sc       (sc.delay_side)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata            = s_q.rdata;
  assign reg_rvalid           = s_q.rvalid;
  assign node_address         = s_q.node_addr;
  assign auto_addr_mode       = s_q.auto_mode;
  // a zero count parks the multiplexer on sense input 1 [R2]
  assign idle_channel         = (count_eff == 5'h00) ? 5'h01 : count_eff;
  assign cell_ov_fault        = s_q.ov_fault;
  assign cell_uv_fault        = s_q.uv_fault;
  assign hysteresis_on        = s_q.dev_opt[HYST_BIT]; // [R10]
  // consumers of fault latching just follow this level [R11]
  assign faults_unlatched     = s_q.dev_opt[UNLATCH_BIT];
  // a pending system reset keeps the supply alive whatever software asked [R5] [R6]
  assign regulator_drive      = !s_q.dev_opt[REG_DIS_BIT] || system_reset_flag;
  assign sample_go            = sc.sample_go; // [R13]
  assign sample_wait          = sc.busy;
  assign frontend_power_delay = sc.delay_on;
  assign baud_sel             = s_q.link_opt[BAUD_LSB +: 2];
  assign bit_period_cycles    = s_q.bit_period;
  assign tx_pin               = s_q.tx;
  assign fault_n_pin          = s_q.fault_n;
  assign upper_receiver_on    = s_q.link_opt[UPPER_RX_BIT];  // [R18]
  assign lower_transmitter_on = s_q.link_opt[LOWER_TX_BIT];  // [R19]
  assign fault_receiver_on    = s_q.link_opt[FAULT_RX_BIT];  // [R20]
  assign fault_heartbeat_on   = s_q.link_opt[HEARTBEAT_BIT]; // [R21]

endmodule

// ---- sample_ctrl_if.sv ----
// carrier between the register bank and the front-end sampling delay
interface sample_ctrl_if;
  logic       sample_req;
  logic       sample_done;
  logic       pwr_wr;
  logic [7:0] pwr_val;
  logic       sample_go;
  logic       delay_on;
  logic       busy;

  modport cfg_side (
    output sample_req,
    output sample_done,
    output pwr_wr,
    output pwr_val,
    input  sample_go,
    input  delay_on,
    input  busy
  );

  modport delay_side (
    input  sample_req,
    input  sample_done,
    input  pwr_wr,
    input  pwr_val,
    output sample_go,
    output delay_on,
    output busy
  );
endinterface

// ---- tb.sv ----
// bench for the monitor configuration register bank
module tb
  import monitor_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 4;
  logic        core_clk, rst, comm_reset, reg_wr, reg_rd, reg_rvalid, tx_raw, fault_n_raw;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, bit_period_cycles;
  logic [4:0]  gpio_addr_pin, addr_assign_val, node_address, idle_channel;
  logic        auto_address_cmd, addr_assign, frame_received, auto_addr_mode;
  logic [15:0] channel_active, ov_comp_on, uv_comp_on, cell_ov_raw, cell_uv_raw;
  logic [15:0] cell_ov_fault, cell_uv_fault;
  logic        hysteresis_on, faults_unlatched, system_reset_flag, regulator_drive;
  logic        sample_req, sample_done, sample_go, sample_wait, frontend_power_delay;
  logic [1:0]  baud_sel;
  logic        tx_pin, fault_n_pin, upper_receiver_on, lower_transmitter_on, fault_receiver_on;
  logic        fault_heartbeat_on;
  logic [7:0]  cnts[4] = '{8'h00, 8'h01, 8'h0f, 8'h10};
  int          bad_count, n_tests;

  monitor_config_registers #(.DELAY_CYCLES(DLY)) dut (
    .core_clk, .rst, .comm_reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .gpio_addr_pin, .auto_address_cmd, .addr_assign, .addr_assign_val,
    .frame_received, .node_address, .auto_addr_mode, .channel_active, .idle_channel,
    .ov_comp_on, .uv_comp_on, .cell_ov_raw, .cell_uv_raw, .cell_ov_fault, .cell_uv_fault,
    .hysteresis_on, .faults_unlatched, .system_reset_flag, .regulator_drive, .sample_req,
    .sample_done, .sample_go, .sample_wait, .frontend_power_delay, .baud_sel,
    .bit_period_cycles, .tx_raw, .fault_n_raw, .tx_pin, .fault_n_pin, .upper_receiver_on,
    .lower_transmitter_on, .fault_receiver_on, .fault_heartbeat_on
  );
  frontend_model #(.LAT(3)) fe (.core_clk, .rst, .sample_go, .sample_done);

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // **********
  // access tasks
  // **********
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // let registered pins follow
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 16'h1, 16'(reg_rvalid));
    chk("read data", 16'(exp), 16'(reg_rdata));
  endtask
  // pulse bits: comm reset, sample, cmd, assign, frame
  task automatic kick(logic [4:0] k);
    @(posedge core_clk);
    {comm_reset, sample_req, auto_address_cmd, addr_assign, frame_received} <= k;
    @(posedge core_clk);
    {comm_reset, sample_req, auto_address_cmd, addr_assign, frame_received} <= 5'h0;
    #1;
  endtask
  task automatic sample(int exp);
    int k = 0;
    kick(5'b01000);
    while (sample_go !== 1'b1 && k < 50)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 50)
    begin
      bad_count++;
      give_verdict();
    end
    chk("sample latency", 16'(exp), 16'(k));
    repeat (6) @(posedge core_clk);
  endtask
  function automatic logic [15:0] cmask(logic [7:0] c);
    return (c >= 8'h10) ? 16'hffff : 16'((17'h1 << c) - 17'h1);
  endfunction

  // **********
  // scenarios
  // **********
  initial
  begin
    rst = 1'b1;
    {comm_reset, reg_wr, reg_rd, auto_address_cmd, addr_assign, frame_received} = 6'h0;
    {system_reset_flag, sample_req, tx_raw} = 3'h0;
    fault_n_raw = 1'b1;
    {reg_addr, reg_wdata} = 16'h0;
    addr_assign_val = 5'h03;
    gpio_addr_pin = 5'h0b;
    {cell_ov_raw, cell_uv_raw} = 32'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_CHAN_COUNT, {3'h0, CHAN_COUNT_RST});
    rd(ADDR_DEV_OPT, DEV_OPT_RST);
    rd(ADDR_PWR_OPT, PWR_OPT_RST);
    rd(ADDR_LINK_HI, LINK_OPT_RST[15:8]);
    rd(ADDR_LINK_LO, LINK_OPT_RST[7:0]);
    rd(8'h12, 8'h00);
    foreach (cnts[i])
    begin
      wr(ADDR_CHAN_COUNT, cnts[i]);
      chk("channel_active", cmask(cnts[i]), channel_active);
      chk("idle_channel", (cnts[i] == 0) ? 16'h1 : 16'(cnts[i]), 16'(idle_channel));
      rd(ADDR_CHAN_COUNT, cnts[i]);
    end
    wr(ADDR_CHAN_COUNT, 8'h05);
    for (int c = 0; c < 3; c++)
    begin
      wr(ADDR_DEV_OPT, 8'(c * 5));
      chk("ov_comp_on", (c < 2) ? 16'h001f : 16'h0, ov_comp_on);
      chk("uv_comp_on", (c == 0) ? 16'h001f : 16'h0, uv_comp_on);
      chk("hysteresis_on", 16'(c == 2), 16'(hysteresis_on));
      chk("faults_unlatched", 16'(c == 1), 16'(faults_unlatched));
    end
    wr(ADDR_DEV_OPT, 8'h00);
    @(posedge core_clk) {cell_ov_raw, cell_uv_raw} <= 32'hffff_ffff;
    repeat (2) @(posedge core_clk);
    #1;
    chk("cell_ov_fault", 16'h001f, cell_ov_fault);
    chk("cell_uv_fault", 16'h001f, cell_uv_fault);
    @(posedge core_clk) {cell_ov_raw, cell_uv_raw} <= 32'h0;
    wr(ADDR_DEV_OPT, 8'h20);
    chk("regulator_drive", 16'h0, 16'(regulator_drive));
    @(posedge core_clk) system_reset_flag <= 1'b1;
    #1;
    chk("regulator_drive", 16'h1, 16'(regulator_drive));
    @(posedge core_clk) system_reset_flag <= 1'b0;
    wr(ADDR_DEV_OPT, 8'h00);
    chk("regulator_drive", 16'h1, 16'(regulator_drive));
    kick(5'b00100);
    chk("node_address", 16'h0b, 16'(node_address));
    wr(ADDR_DEV_OPT, 8'h10);
    chk("node_address", 16'h0b, 16'(node_address));
    kick(5'b00010);
    chk("node_address", 16'h0b, 16'(node_address));
    kick(5'b00100);
    chk("auto_addr_mode", 16'h1, 16'(auto_addr_mode));
    kick(5'b00010);
    chk("node_address", 16'h03, 16'(node_address));
    kick(5'b00001);
    chk("auto_addr_mode", 16'h0, 16'(auto_addr_mode));
    for (int b = 0; b < 4; b++)
    begin
      wr(ADDR_LINK_HI, 8'(b << 4));
      chk("baud_sel", 16'(b), 16'(baud_sel));
      chk("bit_period_cycles", 16'(80 >> b), 16'(bit_period_cycles));
    end
    kick(5'b10000);
    chk("baud_sel", 16'(BAUD_250K), 16'(baud_sel));
    for (int i = 3; i < 8; i++)
    begin
      wr(ADDR_LINK_LO, 8'h1 << i);
      chk("link pins", (i == 7) ? 16'h10 : 16'h20 | 16'h1 << (i - 3), 16'({tx_pin,
          fault_n_pin, upper_receiver_on, lower_transmitter_on, fault_receiver_on,
          fault_heartbeat_on}));
    end
    rd(ADDR_LINK_LO, 8'h80);
    sample(DLY);
    wr(ADDR_PWR_OPT, 8'h00);
    chk("frontend_power_delay", 16'h1, 16'(frontend_power_delay));
    sample(DLY);
    chk("frontend_power_delay", 16'h0, 16'(frontend_power_delay));
    sample(0);
    wr(ADDR_PWR_OPT, 8'h80);
    sample(0);
    sample(DLY);
    give_verdict();
  end
endmodule
